// >>> imb_pkg.sv
// Purpose: Shared constants for the interrupt mask bank.
// Assumes: 32-bit classic Wishbone, byte address = 4 * register index.
// Notes:   Every offset and field position lives here, and the reset byte of the groups.
`default_nettype none
package imb_pkg;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_POST_CLEAR_0   = 8'h00_DA; // Posted group 0.
  localparam logic [7:0] IDX_POST_CLEAR_1   = 8'h00_DB; // Posted group 1.
  localparam logic [7:0] IDX_POST_CLEAR_2   = 8'h00_DC; // Posted group 2.
  localparam logic [7:0] IDX_SOFT_POST_CTRL = 8'h00_DE; // Read-only view.
  localparam logic [7:0] IDX_MASK_TWO       = 8'h00_DF; // Mask group two.
  localparam logic [7:0] IDX_MASK_ZERO      = 8'h00_E0; // Mask group zero.
  localparam logic [7:0] IDX_MASK_ONE       = 8'h00_E1; // Mask group one.
  localparam logic [7:0] IDX_SOFT_POST_SET  = 8'h00_E4; // Writable enable.
  localparam logic [7:0] IDX_EVENT_STATUS   = 8'h00_E5; // Sticky events.
  localparam logic [7:0] IDX_EVENT_MASK     = 8'h00_E6; // Event mask.

  // ---------------------------------------------------------------------
  // Field layouts: implemented bits of each 8-bit group
  // ---------------------------------------------------------------------
  localparam logic [7:0] GROUP0_VALID = 8'h00_FD; // Bit 1 reserved.
  localparam logic [7:0] GROUP1_VALID = 8'h00_60; // Bits 6 and 5.
  localparam logic [7:0] GROUP2_VALID = 8'h00_16; // Bits 4, 2 and 1.
  localparam int         SOFT_EN_BIT  = 7;        // Enable in view reg.
  localparam int         SOFT_SET_BIT = 0;        // Enable in set reg.
  localparam int         G0_GPIO1_BIT = 7;        // GPIO port 1 in grp 0.
  localparam int         G0_GPIO0_BIT = 4;        // GPIO port 0 in grp 0.
  localparam int         G2_GPIO2_BIT = 4;        // GPIO port 2 in grp 2.
  localparam int         EV_HW_POST   = 0;        // Hardware post seen.
  localparam int         EV_SW_POST   = 1;        // Software post seen.
  localparam int         EV_HIDDEN    = 2;        // Post while masked.
  localparam int         EV_WIDTH     = 3;        // Event bit count.
  localparam logic [7:0] RESET_BYTE   = 8'h00_00; // All masked, none set.

endpackage : imb_pkg
`default_nettype wire

// >>> imb_post_bank.sv
// Purpose: One group of posted interrupt flags with post/clear writes.
// Assumes: Write strobe is a single-cycle pulse from the bus slave.
// Notes:   A hardware post in the clearing cycle survives the clear.
`timescale 1ns/1ps
`default_nettype none
module imb_post_bank #(
  parameter logic [7:0] VALID = 8'h00_FF
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] hw_post,
  input  wire logic       wr_stb,
  input  wire logic [7:0] wr_data,
  input  wire logic       soft_en,
  output logic      [7:0] posted_reg,
  output logic      [7:0] soft_set
);

  // ---------------------------------------------------------------------
  // Decode of the written byte
  // ---------------------------------------------------------------------
  logic [7:0] clear_cmd; // Bits the write asks to clear.

  // Zeros clear only while software posting is off; ones are then ignored.
  assign clear_cmd = (wr_stb && !soft_en) ? (~wr_data & VALID)
                                          : imb_pkg::RESET_BYTE;
  // Ones post only while software posting is on; zeros are then ignored.
  assign soft_set  = (wr_stb && soft_en) ? (wr_data & VALID)
                                         : imb_pkg::RESET_BYTE;

  // ---------------------------------------------------------------------
  // Posted flags
  // ---------------------------------------------------------------------
  // Posting ignores the mask entirely; setting wins over a clear.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      posted_reg <= imb_pkg::RESET_BYTE;
    end else begin
      posted_reg <= ((posted_reg & ~clear_cmd) | ((hw_post | soft_set)
                     & VALID));
    end
  end

endmodule : imb_post_bank
`default_nettype wire

// >>> imb_mask_bank.sv
// Purpose: Interrupt mask bank with posted flags and pending outputs.
// Assumes: Classic Wishbone slave, 32-bit data, one-wait registered ack.
// Notes:   Pending is the AND of posted flag and mask, every cycle.
`timescale 1ns/1ps
`default_nettype none
module imb_mask_bank #(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [7:0]            src_event0,
  input  wire logic [7:0]            src_event1,
  input  wire logic [7:0]            src_event2,
  input  wire logic [2:0]            gpio_port_level,
  output logic      [7:0]            pending0,
  output logic      [7:0]            pending1,
  output logic      [7:0]            pending2,
  output logic                       irq
);

  // ---------------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------------
  // The highest byte address needs ten address bits, and the check that
  // the bits above them are zero needs at least one more, so eleven is
  // the least width that the decode below can serve.
  generate
    if (ADDR_WIDTH < 11) begin : g_bad_width
      $error("imb_mask_bank: ADDR_WIDTH must be at least 11");
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  // Bus side state first, then the mask bank, then the source paths.
  logic       ack_reg;          // Registered acknowledge.
  logic [31:0] dat_reg;         // Registered read data.
  logic       req;              // A new bus request is present.
  logic       wr_take;          // Write takes effect at this edge.
  logic [7:0] wr_idx;           // Register index of the access.
  logic       idx_hit_range;    // Upper address bits are zero.
  logic [7:0] wr_byte;          // Written low byte.
  logic [7:0] mask0_reg;        // Mask group zero.
  logic [7:0] mask1_reg;        // Mask group one.
  logic [7:0] mask2_reg;        // Mask group two.
  logic       soft_post_reg;    // Software post enable.
  logic [2:0] gpio_prev_reg;    // Last sampled GPIO port levels.
  logic [2:0] gpio_edge;        // Level change of each port.
  logic [7:0] hw0;              // Hardware posts, group zero.
  logic [7:0] hw1;              // Hardware posts, group one.
  logic [7:0] hw2;              // Hardware posts, group two.
  logic [7:0] posted0;          // Posted flags, group zero.
  logic [7:0] posted1;          // Posted flags, group one.
  logic [7:0] posted2;          // Posted flags, group two.
  logic [7:0] sset0;            // Software posts, group zero.
  logic [7:0] sset1;            // Software posts, group one.
  logic [7:0] sset2;            // Software posts, group two.
  logic [imb_pkg::EV_WIDTH-1:0] ev_status_reg; // Sticky event bits.
  logic [imb_pkg::EV_WIDTH-1:0] ev_mask_reg;   // Event interrupt mask.
  logic [imb_pkg::EV_WIDTH-1:0] ev_set;        // Events this cycle.
  logic [imb_pkg::EV_WIDTH-1:0] ev_clr;        // Write-one-to-clear.

  // The index helper below serves the read mux, the write decode and the bank
  // strobes alike, so one address decode feeds all three.
  // Compare the access index against a register index.
  function automatic logic is_idx(input logic [7:0] idx);
    is_idx = idx_hit_range && (wr_idx == idx);
  endfunction : is_idx

  // Byte with one reserved-to-zero layout applied.
  function automatic logic [31:0] rd_byte(input logic [7:0] v,
                                          input logic [7:0] valid);
    rd_byte = {24'h00_0000, v & valid};
  endfunction : rd_byte

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  // The ack is registered so that it drops in the cycle after it is given.
  // A request is only seen while ack is low, so a master that holds its
  // strobe through the ack cycle is never taken twice.
  // Writes land on the ack edge, the edge at which the master sees ack.
  assign req           = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_take       = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i &&
                         wb_sel_i[0];
  assign wr_idx        = wb_adr_i[9:2];
  assign idx_hit_range = (wb_adr_i[ADDR_WIDTH-1:10] == '0);
  assign wr_byte       = wb_dat_i[7:0];
  assign wb_ack_o      = ack_reg;
  assign wb_dat_o      = dat_reg;

  // Acknowledge every access, mapped or not, one cycle after the request.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // Read data is captured together with the ack; unmapped reads give zero.
  // The value is frozen at the request edge, so a post that lands while
  // the ack is out shows up only on the next read.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dat_reg <= 32'h0000_0000;
    end else if (req) begin
      if (is_idx(imb_pkg::IDX_POST_CLEAR_0)) begin
        dat_reg <= rd_byte(posted0, imb_pkg::GROUP0_VALID);
      end else if (is_idx(imb_pkg::IDX_POST_CLEAR_1)) begin
        dat_reg <= rd_byte(posted1, imb_pkg::GROUP1_VALID);
      end else if (is_idx(imb_pkg::IDX_POST_CLEAR_2)) begin
        dat_reg <= rd_byte(posted2, imb_pkg::GROUP2_VALID);
      end else if (is_idx(imb_pkg::IDX_SOFT_POST_CTRL)) begin
        // Only the enable bit is shown; bits 6 to 0 read as zero.
        dat_reg <= 32'(soft_post_reg) << imb_pkg::SOFT_EN_BIT;
      end else if (is_idx(imb_pkg::IDX_MASK_TWO)) begin
        dat_reg <= rd_byte(mask2_reg, imb_pkg::GROUP2_VALID);
      end else if (is_idx(imb_pkg::IDX_MASK_ZERO)) begin
        dat_reg <= rd_byte(mask0_reg, imb_pkg::GROUP0_VALID);
      end else if (is_idx(imb_pkg::IDX_MASK_ONE)) begin
        dat_reg <= rd_byte(mask1_reg, imb_pkg::GROUP1_VALID);
      end else if (is_idx(imb_pkg::IDX_SOFT_POST_SET)) begin
        dat_reg <= 32'(soft_post_reg) << imb_pkg::SOFT_SET_BIT;
      end else if (is_idx(imb_pkg::IDX_EVENT_STATUS)) begin
        dat_reg <= 32'(ev_status_reg);
      end else if (is_idx(imb_pkg::IDX_EVENT_MASK)) begin
        dat_reg <= 32'(ev_mask_reg);
      end else begin
        dat_reg <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Mask registers
  // ---------------------------------------------------------------------
  // Reserved positions are never stored, so they cannot mask anything.
  // A write with byte lane zero disabled leaves every mask untouched.
  // Writes to unmapped indices are acknowledged and dropped.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mask0_reg <= imb_pkg::RESET_BYTE;
      mask1_reg <= imb_pkg::RESET_BYTE;
      mask2_reg <= imb_pkg::RESET_BYTE;
    end else if (wr_take) begin
      if (is_idx(imb_pkg::IDX_MASK_ZERO)) begin
        mask0_reg <= wr_byte & imb_pkg::GROUP0_VALID;
      end else if (is_idx(imb_pkg::IDX_MASK_ONE)) begin
        mask1_reg <= wr_byte & imb_pkg::GROUP1_VALID;
      end else if (is_idx(imb_pkg::IDX_MASK_TWO)) begin
        mask2_reg <= wr_byte & imb_pkg::GROUP2_VALID;
      end
    end
  end

  // The enable is shown read-only; software changes it through its own
  // writable register, so a stray write to the view cannot flip it.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      soft_post_reg <= 1'b0;
    end else if (wr_take && is_idx(imb_pkg::IDX_SOFT_POST_SET)) begin
      soft_post_reg <= wr_byte[imb_pkg::SOFT_SET_BIT];
    end
  end

  // ---------------------------------------------------------------------
  // Source conditioning
  // ---------------------------------------------------------------------
  // GPIO ports post on any change of their level, never on the level.
  // The previous level resets low, so a port that is already high when
  // reset lifts posts once; software clears that post if unwanted.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gpio_prev_reg <= 3'h0;
    end else begin
      gpio_prev_reg <= gpio_port_level;
    end
  end

  assign gpio_edge = gpio_port_level ^ gpio_prev_reg;

  // GPIO positions take the edges; other positions take the pulse inputs.
  // Pulses on GPIO positions are dropped so that a stray pulse cannot
  // stand in for an edge.
  always_comb begin
    hw0 = src_event0 & imb_pkg::GROUP0_VALID;
    hw1 = src_event1 & imb_pkg::GROUP1_VALID;
    hw2 = src_event2 & imb_pkg::GROUP2_VALID;
    hw0[imb_pkg::G0_GPIO0_BIT] = gpio_edge[0];
    hw0[imb_pkg::G0_GPIO1_BIT] = gpio_edge[1];
    hw2[imb_pkg::G2_GPIO2_BIT] = gpio_edge[2];
  end

  // ---------------------------------------------------------------------
  // Posted flag banks
  // ---------------------------------------------------------------------
  // Each group has its own bank; the bank keeps set over clear, so a
  // hardware post in the clearing cycle is never lost.
  imb_post_bank #(.VALID(imb_pkg::GROUP0_VALID)) u_bank0 (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .hw_post    (hw0),
    .wr_stb     (wr_take && is_idx(imb_pkg::IDX_POST_CLEAR_0)),
    .wr_data    (wr_byte),
    .soft_en    (soft_post_reg),
    .posted_reg (posted0),
    .soft_set   (sset0)
  );

  imb_post_bank #(.VALID(imb_pkg::GROUP1_VALID)) u_bank1 (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .hw_post    (hw1),
    .wr_stb     (wr_take && is_idx(imb_pkg::IDX_POST_CLEAR_1)),
    .wr_data    (wr_byte),
    .soft_en    (soft_post_reg),
    .posted_reg (posted1),
    .soft_set   (sset1)
  );

  imb_post_bank #(.VALID(imb_pkg::GROUP2_VALID)) u_bank2 (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .hw_post    (hw2),
    .wr_stb     (wr_take && is_idx(imb_pkg::IDX_POST_CLEAR_2)),
    .wr_data    (wr_byte),
    .soft_en    (soft_post_reg),
    .posted_reg (posted2),
    .soft_set   (sset2)
  );

  // ---------------------------------------------------------------------
  // Pending requests
  // ---------------------------------------------------------------------
  // Unmasking a source that already posted makes it pend at once.
  assign pending0 = posted0 & mask0_reg;
  assign pending1 = posted1 & mask1_reg;
  assign pending2 = posted2 & mask2_reg;

  // ---------------------------------------------------------------------
  // Event status and interrupt line
  // ---------------------------------------------------------------------
  // Bit 0 flags any hardware post, bit 1 any software post, and bit 2 a
  // hardware post to a source whose mask is clear.
  assign ev_set[imb_pkg::EV_HW_POST] = |{hw0, hw1, hw2};
  assign ev_set[imb_pkg::EV_SW_POST] = |{sset0, sset1, sset2};
  assign ev_set[imb_pkg::EV_HIDDEN]  = |{hw0 & ~mask0_reg, hw1 & ~mask1_reg,
                                         hw2 & ~mask2_reg};
  assign ev_clr = (wr_take && is_idx(imb_pkg::IDX_EVENT_STATUS)) ?
                  wr_byte[imb_pkg::EV_WIDTH-1:0] : '0;

  // Sticky status: a new event in the clearing cycle is kept.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ev_status_reg <= '0;
    end else begin
      ev_status_reg <= (ev_status_reg & ~ev_clr) | ev_set;
    end
  end

  // Event mask, one enable per status bit.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ev_mask_reg <= '0;
    end else if (wr_take && is_idx(imb_pkg::IDX_EVENT_MASK)) begin
      ev_mask_reg <= wr_byte[imb_pkg::EV_WIDTH-1:0];
    end
  end

  // The line is a level: it stays high until software clears the status
  // bit or closes its mask.
  assign irq = |(ev_status_reg & ev_mask_reg);

endmodule : imb_mask_bank
`default_nettype wire

// >>> imb_mask_bank_chk.sv
// Purpose: Concurrent checks on the ports of the interrupt mask bank.
// Assumes: Byte address is four times the register index.
// Notes:   Sees only the top ports; attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module imb_mask_bank_chk #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic [7:0]            src_event0,
  input wire logic [7:0]            src_event1,
  input wire logic [7:0]            src_event2,
  input wire logic [2:0]            gpio_port_level,
  input wire logic [7:0]            pending0,
  input wire logic [7:0]            pending1,
  input wire logic [7:0]            pending2,
  input wire logic                  irq
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // A request taken at this edge, and a taken write with a zero low byte.
  wire take = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire wz   = take & wb_we_i & wb_sel_i[0] & (wb_dat_i[7:0] == 8'h00);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // The slave answers exactly one cycle after taking a request.
  AST_ACK_AFTER_REQ: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_ONE_CYCLE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_NEEDS_REQ: assert property (!(wb_cyc_i & wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  // Leaving reset, nothing pends and the line is quiet.
  AST_RESET_QUIET: assert property ($rose(rst_n) |->
    {pending0, pending1, pending2, irq} == 25'h000_0000)
    else $error("pending after reset");
  AST_VIEW_RES: assert property (take && !wb_we_i &&
    wb_adr_i == ADDR_WIDTH'(12'h378) |=> wb_dat_o[6:0] == 7'h00)
    else $error("reserved view bits read nonzero");
  // Reserved positions never pend.
  AST_GRP0_RES: assert property (pending0[1] == 1'b0)
    else $error("group zero bit 1 pending");
  AST_GRP1_RES: assert property ((pending1 & 8'h9F) == 8'h00)
    else $error("group one reserved bit pending");
  AST_GRP2_RES: assert property ((pending2 & 8'hE9) == 8'h00)
    else $error("group two reserved bit pending");
  // Closing every mask stops every pending output of that group.
  AST_MASK2_CLOSE: assert property (wz && wb_adr_i ==
    ADDR_WIDTH'(12'h37C) |=> ##1 pending2 == 8'h00)
    else $error("group two pends while masked");
  AST_MASK0_CLOSE: assert property (wz && wb_adr_i ==
    ADDR_WIDTH'(12'h380) |=> ##1 pending0 == 8'h00)
    else $error("group zero pends while masked");

  // ---------------------------------------------------------------
  // Covers
  // ---------------------------------------------------------------
  COV_IRQ: cover property ($rose(irq));
  COV_GPIO2: cover property ($rose(pending2[4]));
  COV_WRITE: cover property (take && wb_we_i);
endmodule : imb_mask_bank_chk

bind imb_mask_bank imb_mask_bank_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .src_event0(src_event0), .src_event1(src_event1),
  .src_event2(src_event2), .gpio_port_level(gpio_port_level),
  .pending0(pending0), .pending1(pending1), .pending2(pending2),
  .irq(irq));
`default_nettype wire

// >>> imb_mask_bank_tb.sv
// Purpose: Self-checking bench for the interrupt mask bank.
// Assumes: One-cycle registered ack; posts land one edge after a pulse.
// Notes:   A shadow of posted flags and masks predicts every pending output and posted read.
`timescale 1ns/1ps
`default_nettype none
module imb_mask_bank_tb;
  // ---------------------------------------------------------------
  // Signals and shadow state
  // ---------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [11:0] adr     = 12'h000;
  logic [3:0]  sel     = 4'h0;
  logic [31:0] wdat    = 32'h0000_0000;
  logic [2:0]  gpio    = 3'h0;
  logic [7:0]  ev [3]  = '{8'h00, 8'h00, 8'h00};
  wire  [31:0] rdat;
  wire         ack, irq;
  wire  [7:0]  pend [3];
  logic [7:0]  p [3], m [3];  // Expected posted flags and masks.
  int          err_total = 0, cmp_count = 0, cyc_cnt = 0;
  // Per group: implemented bits, mask index, post index, pulse bits.
  localparam logic [7:0] VAL [3] = '{imb_pkg::GROUP0_VALID,
    imb_pkg::GROUP1_VALID, imb_pkg::GROUP2_VALID};
  localparam logic [7:0] MI [3] = '{imb_pkg::IDX_MASK_ZERO,
    imb_pkg::IDX_MASK_ONE, imb_pkg::IDX_MASK_TWO};
  localparam logic [7:0] PI [3] = '{imb_pkg::IDX_POST_CLEAR_0,
    imb_pkg::IDX_POST_CLEAR_1, imb_pkg::IDX_POST_CLEAR_2};
  // GPIO positions ignore pulses, so they are left out here.
  localparam logic [7:0] HW [3] = '{8'h6D, 8'h60, 8'h06};

  always #5 clk_sys = ~clk_sys;

  imb_mask_bank dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .src_event0(ev[0]), .src_event1(ev[1]), .src_event2(ev[2]),
    .gpio_port_level(gpio), .pending0(pend[0]), .pending1(pend[1]),
    .pending2(pend[2]), .irq(irq));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One classic cycle; the request stands until ack is sampled high.
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'h1;
    adr <= {2'b00, idx, 2'b00}; wdat <= {24'h00_0000, d};
    // Only the bench's cycle ceiling ends a wait for the answer.
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    chk("ack", 8'h01, {7'h00, ack});
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, idx, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, idx, 8'h00, q);
    chk("read", e, q);
  endtask : rd_chk

  // Random hardware pulses for one cycle in every group.
  task automatic hw_post;
    logic [7:0] d;
    @(posedge clk_sys);
    for (int g = 0; g < 3; g++) begin
      d = 8'($urandom) | 8'h01;
      ev[g] <= d;
      p[g] |= d & HW[g];
    end
    @(posedge clk_sys);
    for (int g = 0; g < 3; g++) ev[g] <= 8'h00;
  endtask : hw_post

  // Pending is the AND of posted and mask; reads show posted flags.
  task automatic chk_all;
    @(posedge clk_sys);
    #1;
    for (int g = 0; g < 3; g++) begin
      chk("pending", p[g] & m[g], pend[g]);
      rd_chk(PI[g], p[g]);
    end
  endtask : chk_all

  // Cuts a hang short and counts it as a mismatch.
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt > 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] d;
    void'($urandom(32'h5832));
    for (int g = 0; g < 3; g++) begin
      p[g] = 8'h00;
      m[g] = 8'h00;
    end
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int g = 0; g < 3; g++) rd_chk(MI[g], 8'h00);
    rd_chk(imb_pkg::IDX_SOFT_POST_CTRL, 8'h00);
    rd_chk(8'hF0, 8'h00);
    // All ones, all zeros and random patterns; reserved bits stay 0.
    for (int g = 0; g < 3; g++) begin
      for (int i = 0; i < 4; i++) begin
        d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
        wr(MI[g], d);
        rd_chk(MI[g], d & VAL[g]);
      end
      wr(MI[g], 8'hFF);
      m[g] = VAL[g];
    end
    wr(imb_pkg::IDX_SOFT_POST_CTRL, 8'hFF);
    rd_chk(imb_pkg::IDX_SOFT_POST_CTRL, 8'h00);
    repeat (3) hw_post();
    chk_all();
    for (int g = 0; g < 3; g++) begin
      d = 8'($urandom);
      wr(PI[g], d);
      p[g] &= d;
    end
    chk_all();
    wr(imb_pkg::IDX_SOFT_POST_SET, 8'h01);
    rd_chk(imb_pkg::IDX_SOFT_POST_CTRL, 8'h80);
    for (int g = 0; g < 3; g++) begin
      d = 8'($urandom);
      wr(PI[g], d);
      p[g] |= d & VAL[g];
    end
    chk_all();
    wr(imb_pkg::IDX_SOFT_POST_SET, 8'h00);
    for (int g = 0; g < 3; g++) begin
      wr(PI[g], 8'h00);
      p[g] = 8'h00;
      wr(MI[g], 8'h00);
      m[g] = 8'h00;
    end
    hw_post();
    chk_all();
    for (int g = 0; g < 3; g++) begin
      wr(PI[g], 8'h00);
      p[g] = 8'h00;
      wr(MI[g], 8'hFF);
      m[g] = VAL[g];
    end
    // Every port level flips once, then holds steady after a clear.
    @(posedge clk_sys);
    gpio <= 3'h7;
    p[0] |= 8'h90;
    p[2] |= 8'h10;
    repeat (2) @(posedge clk_sys);
    chk_all();
    wr(PI[0], 8'h00);
    wr(PI[2], 8'h00);
    p[0] = 8'h00;
    p[2] = 8'h00;
    repeat (3) @(posedge clk_sys);
    chk_all();
    // Raise, mask and clear the summary interrupt.
    wr(imb_pkg::IDX_EVENT_STATUS, 8'h07);
    wr(imb_pkg::IDX_EVENT_MASK, 8'h00);
    hw_post();
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq masked", 8'h00, {7'h00, irq});
    rd_chk(imb_pkg::IDX_EVENT_STATUS, 8'h01);
    wr(imb_pkg::IDX_EVENT_MASK, 8'h01);
    @(posedge clk_sys);
    #1;
    chk("irq raised", 8'h01, {7'h00, irq});
    wr(imb_pkg::IDX_EVENT_STATUS, 8'h01);
    @(posedge clk_sys);
    #1;
    chk("irq cleared", 8'h00, {7'h00, irq});
    wrap_up();
  end
endmodule : imb_mask_bank_tb
`default_nettype wire
